/* File: design/dnws_channel.sv */
// dma channel end: apb registers, dual-port ram port, null write and start logic
// Operation
// (R01) null write with every peripheral read
// (R02) zero write concurrent with ram write
// (R03) zero write only when servicing request
// (R04) software writes peripheral once to start
// (R05) forced read still reads, advances pointer
// (R06) no transfers until channel enabled
// (R07) re-enable clears count, selects primary buffer
// (R08) peripheral request alone starts transfers
// (R09) transmit master started by forced transfer
// (R10) receive master needs null write, force
// (R11) duplex master started by force or write
// (R12) transmitting slave preloaded by force/write
// (R13) receive slave requests on first data
// (R14) uart receiver requests on each item
// (R15) uart transmitter requests when enabled
// (R16) request before channel enable is dropped
// (R17) force bit makes one request, hardware clears
// (R18) primary start offset gives first address
// (R19) force ignored when disabled; no null on writes
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
module dnws_channel
(
   dnws_link_if.channel LINK,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic RAM_WE_O,
   output logic RAM_RE_O,
   output logic [dnws_pkg::DNWS_AW-1:0] RAM_ADDR_O,
   output logic [dnws_pkg::DNWS_DW-1:0] RAM_WDATA_O,
   input wire logic [dnws_pkg::DNWS_DW-1:0] RAM_RDATA_I
);
   import dnws_pkg::*;

   logic clk;
   logic rst;
   logic [DNWS_CTL_W-1:0] ctrl_r;
   logic [DNWS_AW-1:0] sta_r;
   logic [DNWS_AW-1:0] stb_r;
   logic [DNWS_CW-1:0] cnt_r;
   logic [DNWS_CW-1:0] count_r;
   logic [DNWS_AW-1:0] ptr_r;
   logic buf_r;
   logic force_r;
   logic pend_r;
   logic req_d_r;
   dnws_state_t state_r;
   dnws_state_t state_nxt;
   logic wr_ctrl;
   logic wr_req;
   logic en;
   logic en_rise;
   logic start;
   logic done;
   logic last;
   logic mapped;

   assign clk = LINK.clk;
   assign rst = LINK.rst;

   // ==========================================
   // apb slave
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == DNWS_OFF_CTRL) || (a == DNWS_OFF_REQ) || (a == DNWS_OFF_STA)
                  || (a == DNWS_OFF_STB) || (a == DNWS_OFF_CNT) || (a == DNWS_OFF_STAT);
   endfunction : is_mapped

   assign mapped = is_mapped(PADDR_I);
   assign PREADY_O = PSEL_I & PENABLE_I;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
   assign wr_ctrl = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == DNWS_OFF_CTRL);
   assign wr_req = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == DNWS_OFF_REQ);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         PRDATA_O <= DNWS_WORD_ZERO;
      else if (PSEL_I & ~PENABLE_I & ~PWRITE_I)
      begin
         PRDATA_O <= DNWS_WORD_ZERO;
         case (PADDR_I)
            DNWS_OFF_CTRL: PRDATA_O[DNWS_CTL_W-1:0] <= ctrl_r;
            DNWS_OFF_REQ: PRDATA_O[DNWS_REQ_FORCE] <= force_r;
            DNWS_OFF_STA: PRDATA_O[DNWS_AW-1:0] <= sta_r;
            DNWS_OFF_STB: PRDATA_O[DNWS_AW-1:0] <= stb_r;
            DNWS_OFF_CNT: PRDATA_O[DNWS_CW-1:0] <= cnt_r;
            DNWS_OFF_STAT:
            begin
               PRDATA_O[DNWS_ST_CNT_LSB +: DNWS_CW] <= count_r;
               PRDATA_O[DNWS_ST_BUF] <= buf_r;
               PRDATA_O[DNWS_ST_BUSY] <= (state_r != DNWS_IDLE);
               PRDATA_O[DNWS_ST_PTR_LSB +: DNWS_AW] <= ptr_r;
            end
            default: PRDATA_O <= DNWS_WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sta_r <= '0;
         stb_r <= '0;
         cnt_r <= DNWS_CNT_ZERO;
      end
      else if (PSEL_I & PENABLE_I & PWRITE_I)
      begin
         if (PADDR_I == DNWS_OFF_STA)
            sta_r <= PWDATA_I[DNWS_AW-1:0];
         if (PADDR_I == DNWS_OFF_STB)
            stb_r <= PWDATA_I[DNWS_AW-1:0];
         if (PADDR_I == DNWS_OFF_CNT)
            cnt_r <= PWDATA_I[DNWS_CW-1:0];
      end
   end

   // ==========================================
   // control, enable and force
   assign en = ctrl_r[DNWS_CTL_EN];
   assign en_rise = wr_ctrl & ~en & PWDATA_I[DNWS_CTL_EN];
   assign last = (count_r == cnt_r);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_r <= DNWS_CTL_RST;
      else if (wr_ctrl)
         ctrl_r <= PWDATA_I[DNWS_CTL_W-1:0];
      else if (done & last & ~ctrl_r[DNWS_CTL_CONT] & (~ctrl_r[DNWS_CTL_PP] | buf_r))
         ctrl_r[DNWS_CTL_EN] <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         force_r <= 1'b0;
      else if (wr_req & PWDATA_I[DNWS_REQ_FORCE] & en & ~force_r & ~pend_r & (state_r == DNWS_IDLE))
         force_r <= 1'b1; // see (R17) see (R19)
      else if (done | ~en)
         force_r <= 1'b0; // see (R17)
   end

   // request latched on its rising edge only while enabled
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         req_d_r <= 1'b0;
         pend_r <= 1'b0;
      end
      else
      begin
         req_d_r <= LINK.dma_req;
         if (LINK.dma_req & ~req_d_r & en)
            pend_r <= 1'b1; // see (R08) see (R13) see (R14) see (R16)
         else if (start | ~en)
            pend_r <= 1'b0;
      end
   end

   // ==========================================
   // transfer sequencing
   assign start = (state_r == DNWS_IDLE) & en & ~wr_ctrl & (pend_r | force_r); // see (R06) see (R03)
   assign done = (start & ~ctrl_r[DNWS_CTL_DIR]) | (state_r == DNWS_PUT);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         DNWS_IDLE:
            if (start & ctrl_r[DNWS_CTL_DIR])
               state_nxt = DNWS_FETCH;
         DNWS_FETCH: state_nxt = DNWS_PUT;
         DNWS_PUT: state_nxt = DNWS_IDLE;
         default: state_nxt = DNWS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_r <= DNWS_IDLE;
      else
         state_r <= state_nxt;
   end

   // pointer, count and buffer select
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_r <= DNWS_CNT_ZERO;
         buf_r <= 1'b0;
         ptr_r <= '0;
      end
      else if (en_rise)
      begin
         count_r <= DNWS_CNT_ZERO; // see (R07)
         buf_r <= 1'b0; // see (R07)
         ptr_r <= sta_r; // see (R18)
      end
      else if (done & last)
      begin
         count_r <= DNWS_CNT_ZERO;
         buf_r <= ctrl_r[DNWS_CTL_PP] & ~buf_r;
         ptr_r <= (ctrl_r[DNWS_CTL_PP] & ~buf_r) ? stb_r : sta_r;
      end
      else if (done)
      begin
         count_r <= count_r + DNWS_CNT_ONE; // see (R05)
         ptr_r <= ptr_r + DNWS_PTR_ONE; // see (R05)
      end
   end

   // ==========================================
   // ram and peripheral bus strobes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         RAM_WE_O <= 1'b0;
         RAM_RE_O <= 1'b0;
         RAM_ADDR_O <= '0;
         RAM_WDATA_O <= DNWS_NULL;
         LINK.rd_en <= 1'b0;
         LINK.wr_en <= 1'b0;
         LINK.wr_data <= DNWS_NULL;
         LINK.dma_ack <= 1'b0;
      end
      else
      begin
         RAM_WE_O <= start & ~ctrl_r[DNWS_CTL_DIR];
         RAM_RE_O <= start & ctrl_r[DNWS_CTL_DIR];
         RAM_ADDR_O <= ptr_r;
         LINK.rd_en <= start & ~ctrl_r[DNWS_CTL_DIR]; // see (R05)
         LINK.dma_ack <= done;
         if (start & ~ctrl_r[DNWS_CTL_DIR])
            RAM_WDATA_O <= LINK.rd_data;
         if (state_r == DNWS_PUT)
         begin
            LINK.wr_en <= 1'b1;
            LINK.wr_data <= RAM_RDATA_I;
         end
         else
         begin
            // see (R01) see (R02) see (R19)
            LINK.wr_en <= start & ~ctrl_r[DNWS_CTL_DIR] & ctrl_r[DNWS_CTL_ZERO_WRITE_SELECT];
            LINK.wr_data <= DNWS_NULL;
         end
      end
   end
endmodule : dnws_channel

/* File: design/dnws_link_if.sv */
// link between the dma channel and the serial peripheral data register
`timescale 1ns/1ns
interface dnws_link_if
(
   input wire logic clk,
   input wire logic rst
);
   import dnws_pkg::*;
   logic dma_req;
   logic dma_ack;
   logic rd_en;
   logic [DNWS_DW-1:0] rd_data;
   logic wr_en;
   logic [DNWS_DW-1:0] wr_data;

   modport channel
   (
      input clk, rst, dma_req, rd_data,
      output dma_ack, rd_en, wr_en, wr_data
   );
   modport periph
   (
      input clk, rst, dma_ack, rd_en, wr_en, wr_data,
      output dma_req, rd_data
   );
endinterface : dnws_link_if

/* File: design/dnws_periph.sv */
// peripheral end: serial data register and its dma request generation
`timescale 1ns/1ns
module dnws_periph
(
   dnws_link_if.periph LINK,
   input wire logic UART_MODE_I,
   input wire logic RX_EN_I,
   input wire logic TX_EN_I,
   input wire logic RX_VALID_I,
   input wire logic [dnws_pkg::DNWS_DW-1:0] RX_DATA_I,
   input wire logic TX_DONE_I,
   input wire logic CPU_WR_I,
   input wire logic [dnws_pkg::DNWS_DW-1:0] CPU_WDATA_I,
   output logic TX_START_O,
   output logic [dnws_pkg::DNWS_DW-1:0] TX_DATA_O
);
   import dnws_pkg::*;

   logic clk;
   logic rst;
   logic [DNWS_DW-1:0] rx_buf_r;
   logic req_r;
   logic tx_en_d_r;
   logic set_req;

   assign clk = LINK.clk;
   assign rst = LINK.rst;
   assign LINK.dma_req = req_r;
   assign LINK.rd_data = rx_buf_r;

   // ==========================================
   // request sources
   assign set_req = (RX_VALID_I & RX_EN_I) // see (R13) see (R14)
                    | (TX_DONE_I & TX_EN_I & ~RX_EN_I) // see (R09) see (R12)
                    | (UART_MODE_I & TX_EN_I & ~tx_en_d_r); // see (R15)

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         req_r <= 1'b0;
         tx_en_d_r <= 1'b0;
      end
      else
      begin
         tx_en_d_r <= TX_EN_I;
         if (set_req)
            req_r <= 1'b1;
         else if (LINK.dma_ack)
            req_r <= 1'b0;
      end
   end

   // ==========================================
   // data register; any write starts the shifter
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_buf_r <= DNWS_NULL;
         TX_START_O <= 1'b0;
         TX_DATA_O <= DNWS_NULL;
      end
      else
      begin
         if (RX_VALID_I)
            rx_buf_r <= RX_DATA_I;
         TX_START_O <= LINK.wr_en | CPU_WR_I; // see (R04) see (R10) see (R11)
         if (LINK.wr_en)
            TX_DATA_O <= LINK.wr_data;
         else if (CPU_WR_I)
            TX_DATA_O <= CPU_WDATA_I;
      end
   end
endmodule : dnws_periph

/* File: design/dnws_pkg.sv */
// shared constants for the null-write dma channel and its peripheral end
package dnws_pkg;
   // ==========================================
   // widths
   localparam int DNWS_DW = 16;
   localparam int DNWS_AW = 11;
   localparam int DNWS_CW = 10;
   localparam int DNWS_PAW = 8;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] DNWS_OFF_CTRL = 8'h00;
   localparam logic [7:0] DNWS_OFF_REQ = 8'h04;
   localparam logic [7:0] DNWS_OFF_STA = 8'h08;
   localparam logic [7:0] DNWS_OFF_STB = 8'h0c;
   localparam logic [7:0] DNWS_OFF_CNT = 8'h10;
   localparam logic [7:0] DNWS_OFF_STAT = 8'h14;
   // ==========================================
   // channel_control_reg fields
   localparam int DNWS_CTL_EN = 0;
   localparam int DNWS_CTL_DIR = 1;
   localparam int DNWS_CTL_ZERO_WRITE_SELECT = 2;
   localparam int DNWS_CTL_CONT = 3;
   localparam int DNWS_CTL_PP = 4;
   localparam int DNWS_CTL_W = 5;
   localparam logic [DNWS_CTL_W-1:0] DNWS_CTL_RST = 5'h00;
   // request_select_reg / status fields
   localparam int DNWS_REQ_FORCE = 0;
   localparam int DNWS_ST_CNT_LSB = 0;
   localparam int DNWS_ST_BUF = 16;
   localparam int DNWS_ST_BUSY = 17;
   localparam int DNWS_ST_PTR_LSB = 20;
   // ==========================================
   // values
   localparam logic [DNWS_DW-1:0] DNWS_NULL = 16'h0000;
   localparam logic [DNWS_CW-1:0] DNWS_CNT_ZERO = 10'h000;
   localparam logic [DNWS_CW-1:0] DNWS_CNT_ONE = 10'h001;
   localparam logic [DNWS_AW-1:0] DNWS_PTR_ONE = 11'h001;
   localparam logic [31:0] DNWS_WORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      DNWS_IDLE = 2'b00,
      DNWS_FETCH = 2'b01,
      DNWS_PUT = 2'b10
   } dnws_state_t;
endpackage : dnws_pkg

/* File: testbench/dma_null_write_and_start_test.sv */
// self-checking bench for the null-write dma channel and peripheral
`timescale 1ns/1ns
module dma_null_write_and_start_test;
   import dnws_pkg::*;
   // ==========================================
   // stimulus and monitors
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, we, re, txst, qe;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, q;
   logic [DNWS_AW-1:0] ra, last_a;
   logic [DNWS_DW-1:0] rwd, rrd = 16'h0, txd, last_wd;
   logic [DNWS_DW-1:0] rxd = 16'h0, cpud = 16'h0;
   logic [DNWS_DW-1:0] mem [0:2047];
   logic umode = 1'b1, rxen = 1'b0, txen = 1'b0, rxv = 1'b0, txdone = 1'b0, cpuwr = 1'b0;
   int n_fail = 0, checked = 0, n_we = 0, n_wr = 0, n_rd = 0, n_st = 0;
   always #50 clk = ~clk;
   dnws_link_if u_dnws_link_if (.clk(clk), .rst(rst));
   dnws_channel u_dnws_channel (.LINK(u_dnws_link_if), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .RAM_WE_O(we), .RAM_RE_O(re), .RAM_ADDR_O(ra), .RAM_WDATA_O(rwd), .RAM_RDATA_I(rrd));
   dnws_periph u_dnws_periph (.LINK(u_dnws_link_if), .UART_MODE_I(umode), .RX_EN_I(rxen), .TX_EN_I(txen),
      .RX_VALID_I(rxv), .RX_DATA_I(rxd), .TX_DONE_I(txdone), .CPU_WR_I(cpuwr), .CPU_WDATA_I(cpud),
      .TX_START_O(txst), .TX_DATA_O(txd));
   dnws_chk u_dnws_chk (.clk(clk), .rst(rst), .dma_req(u_dnws_link_if.dma_req),
      .dma_ack(u_dnws_link_if.dma_ack), .rd_en(u_dnws_link_if.rd_en), .rd_data(u_dnws_link_if.rd_data),
      .wr_en(u_dnws_link_if.wr_en), .wr_data(u_dnws_link_if.wr_data));
   always @(posedge clk)
   begin
      if (re === 1'b1) rrd <= mem[ra];
      if (we === 1'b1)
      begin
         mem[ra] <= rwd;
         last_a <= ra;
         n_we <= n_we + 1;
      end
      if (u_dnws_link_if.wr_en === 1'b1)
      begin
         n_wr <= n_wr + 1;
         last_wd <= u_dnws_link_if.wr_data;
      end
      if (u_dnws_link_if.rd_en === 1'b1) n_rd <= n_rd + 1;
      if (txst === 1'b1) n_st <= n_st + 1;
   end
   // ==========================================
   // shared tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prd;
      qe = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task wait_ack;
      int i;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (u_dnws_link_if.dma_ack !== 1'b1 && i < 40);
      repeat (2) @(posedge clk);
   endtask : wait_ack
   task print_verdict;
      if (n_fail == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   // ==========================================
   // scenarios
   task s_tx;
      txen <= 1'b1;
      repeat (10) @(posedge clk);
      apb(1'b1, DNWS_OFF_CNT, 32'h0000_000f);
      apb(1'b1, DNWS_OFF_STA, 32'h0000_0020);
      apb(1'b1, DNWS_OFF_REQ, 32'h0000_0001);
      apb(1'b0, DNWS_OFF_REQ, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0000_0003);
      repeat (10) @(posedge clk);
      chk(32'(n_wr), 32'h0);
      apb(1'b1, DNWS_OFF_REQ, 32'h0000_0001);
      wait_ack;
      chk(32'(n_wr), 32'h1);
      chk(32'(txd), 32'h0000_beef);
      apb(1'b0, DNWS_OFF_REQ, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0);
      txen <= 1'b0;
      apb(1'b1, DNWS_OFF_CTRL, 32'h0000_0003);
      txen <= 1'b1;
      wait_ack;
      chk(32'(n_wr), 32'h2);
      chk(32'(txd), 32'h0000_beef);
      chk(32'(n_rd), 32'h0);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0);
      txen <= 1'b0;
   endtask : s_tx
   task s_rx;
      int s0;
      s0 = n_st;
      rxen <= 1'b1;
      rxd <= 16'h0bad;
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      apb(1'b1, DNWS_OFF_STA, 32'h0000_0010);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0000_0005);
      repeat (10) @(posedge clk);
      chk(32'(n_we), 32'h0);
      apb(1'b1, DNWS_OFF_REQ, 32'h0000_0001);
      wait_ack;
      chk(32'(n_we), 32'h1);
      chk(32'(mem[11'h010]), 32'h0000_0bad);
      chk(32'(last_a), 32'h0000_0010);
      chk(32'(last_wd), 32'h0);
      chk(32'(n_rd), 32'h1);
      chk(32'(n_st - s0), 32'h1);
      rxd <= 16'h1234;
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      wait_ack;
      repeat (10) @(posedge clk);
      chk(32'(mem[11'h011]), 32'h0000_1234);
      chk(32'(n_wr), 32'h4);
      chk(32'(n_st - s0), 32'h2);
      apb(1'b0, DNWS_OFF_STAT, 32'h0);
      chk(q, 32'h0120_0002);
      apb(1'b0, 8'h18, 32'h0);
      chk(32'(qe), 32'h1);
      chk(q, 32'h0);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0000_0005);
      apb(1'b0, DNWS_OFF_STAT, 32'h0);
      chk(q, 32'h0100_0000);
   endtask : s_rx
   task s_spi;
      int w0, s0;
      apb(1'b1, DNWS_OFF_CTRL, 32'h0);
      umode <= 1'b0;
      rxen <= 1'b0;
      txen <= 1'b1;
      apb(1'b1, DNWS_OFF_STA, 32'h0000_0020);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0000_0003);
      w0 = n_wr;
      s0 = n_st;
      repeat (10) @(posedge clk);
      chk(32'(n_wr - w0), 32'h0);
      cpud <= 16'hc0de;
      cpuwr <= 1'b1;
      @(posedge clk);
      cpuwr <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(n_st - s0), 32'h1);
      chk(32'(txd), 32'h0000_c0de);
      txdone <= 1'b1;
      @(posedge clk);
      txdone <= 1'b0;
      wait_ack;
      chk(32'(n_wr - w0), 32'h1);
      chk(32'(txd), 32'h0000_beef);
      rxen <= 1'b1;
      txdone <= 1'b1;
      @(posedge clk);
      txdone <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(n_wr - w0), 32'h1);
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      wait_ack;
      chk(32'(n_wr - w0), 32'h2);
      chk(32'(txd), 32'h0000_5a5a);
      apb(1'b1, DNWS_OFF_CTRL, 32'h0);
      txen <= 1'b0;
      rxen <= 1'b0;
   endtask : s_spi
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      mem[11'h020] = 16'hbeef;
      mem[11'h021] = 16'h5a5a;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_tx;
      s_rx;
      s_spi;
      print_verdict;
   end
   initial
   begin
      #200000;
      n_fail++;
      print_verdict;
   end
endmodule : dma_null_write_and_start_test

/* File: testbench/dnws_chk.sv */
// interface assertions for the null-write dma link
`timescale 1ns/1ns
module dnws_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic dma_req,
   input wire logic dma_ack,
   input wire logic rd_en,
   input wire logic [dnws_pkg::DNWS_DW-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [dnws_pkg::DNWS_DW-1:0] wr_data
);
   import dnws_pkg::*;
   // ==========================================
   // link properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_NULL_ZERO: assert property (rd_en && wr_en |-> wr_data == DNWS_NULL)
      else $error("null write carries data");
   AST_READ_ACK: assert property (rd_en |-> dma_ack)
      else $error("read without ack");
   AST_WRITE_ACK: assert property (wr_en |-> dma_ack)
      else $error("peripheral write outside a transfer");
   AST_ACK_CAUSE: assert property (dma_ack |-> rd_en || wr_en)
      else $error("ack without a transfer");
   AST_ACK_PULSE: assert property (dma_ack |=> !dma_ack)
      else $error("ack longer than one cycle");
   AST_RD_PULSE: assert property (rd_en |=> !rd_en)
      else $error("read strobe longer than one cycle");
   AST_WR_PULSE: assert property ($rose(wr_en) |=> $fell(wr_en))
      else $error("write strobe longer than one cycle");
   AST_REQ_LEVEL: assert property ($rose(dma_req) |-> dma_req [*3])
      else $error("request dropped before service");
endmodule : dnws_chk
